// ### src/serial_link_test_pattern_gen.v
// Test-pattern generator for a six-lane-per-converter serial transmitter.
// Assumes a downstream 8b/10b or 64b/66b encoder fed one octet pair per lane per clock;
// ctrl flags mark K characters for the encoder; inputs synchronous to clk_sys.
`timescale 1ns/1ps
`include "test_pattern_regs.vh"
module serial_link_test_pattern_gen (
	input wire clk_sys,
	input wire rst,
	input wire [2:0] test_mode,
	input wire [1:0] link_config_select,
	input wire enc_8b10b,
	input wire sync_req_n,
	input wire [95:0] conv_a_data,
	input wire [95:0] conv_b_data,
	output reg [95:0] lane_a_q,
	output reg [95:0] lane_b_q,
	output reg [11:0] lane_a_k_q,
	output reg [11:0] lane_b_k_q,
	output reg [5:0] lane_en_q,
	output reg test_active_q
);
	localparam ST_IDLE = 3'b001;
	localparam ST_CGS = 3'b010;
	localparam ST_ILA = 3'b100;

	reg [2:0] st_q;
	reg [2:0] st_d;
	reg [7:0] ila_cnt_q;
	reg [3:0] rpat_idx_q;
	reg [3:0] rpat_idx1;
	wire [7:0] rpat_o0;
	wire [7:0] rpat_o1;
	reg [95:0] pat_d;
	reg [11:0] k_d;
	reg [5:0] en_d;
	reg active_d;
	reg [15:0] word;
	reg [1:0] kw;
	integer i;

	// Second octet index of the pair, first plus one; stays inside the twelve since the first is even
	always @* begin
		rpat_idx1 = rpat_idx_q + 4'h1;
	end

	rpat_rom u_rom0 (
		.idx(rpat_idx_q),
		.octet(rpat_o0)
	);
	rpat_rom u_rom1 (
		.idx(rpat_idx1),
		.octet(rpat_o1)
	);

	// Short pattern octet pair for a lane under a given layout
	function [15:0] short_word;
		input [1:0] cfg;
		input [2:0] lane;
		begin
			case (lane)
				3'h0: short_word = 16'h0123;
				3'h1: short_word = 16'h4567;
				3'h2: short_word = 16'h89AB;
				3'h3: short_word = 16'hCDEF;
				3'h4: short_word = 16'h0123;
				3'h5: short_word = 16'h4567;
				default: short_word = 16'h0000;
			endcase
			if (cfg == `CFG_F2S4 && lane > 3'h2) begin
				short_word = 16'h0000;
			end
		end
	endfunction

	// Repeated-ILA sequencer: CGS while sync is requested, then ILA until sync is requested again
	always @* begin
		st_d = st_q;
		case (st_q)
			ST_IDLE: begin
				if (test_mode == `TM_RILA && enc_8b10b) begin
					st_d = ST_CGS;
				end
			end
			ST_CGS: begin
				if (sync_req_n) begin
					st_d = ST_ILA;
				end
			end
			ST_ILA: begin
				if (!sync_req_n) begin
					st_d = ST_CGS;
				end
			end
			default: st_d = ST_IDLE;
		endcase
		if (test_mode != `TM_RILA || !enc_8b10b) begin
			st_d = ST_IDLE;
		end
	end

	// Lane enables per link configuration; lowest lanes first
	always @* begin
		case (link_config_select)
			`CFG_F2S4: en_d = 6'h07;
			default: en_d = 6'h3F;
		endcase
	end

	// Lane content select; unsupported encoding combinations pass samples
	always @* begin
		pat_d = conv_a_data;
		k_d = 12'h000;
		active_d = 1'b0;
		word = 16'h0000;
		kw = 2'b00;
		for (i = 0; i < `NUM_LANES; i = i + 1) begin
			word = conv_a_data[i*16 +: 16];
			kw = 2'b00;
			case (test_mode)
				`TM_SHORT: begin
					// F8 layout is out of scope; falls back to F2 S8 octets
					word = short_word(link_config_select, i[2:0]);
				end
				`TM_D215: begin
					word = {`CHAR_D215, `CHAR_D215};
				end
				`TM_K285: begin
					if (enc_8b10b) begin
						word = {`CHAR_K285, `CHAR_K285};
						kw = 2'b11;
					end
				end
				`TM_RILA: begin
					// Commas on the entry cycle too, so samples never leak through
					if (st_q != ST_ILA && enc_8b10b) begin
						word = {`CHAR_K285, `CHAR_K285};
						kw = 2'b11;
					end else if (st_q == ST_ILA) begin
						// Marker framing each pass; payload is the octet count
						if (ila_cnt_q == 8'h00) begin
							word = {`CHAR_ILA_START, ila_cnt_q + 8'h01};
							kw = 2'b10;
						end else if (ila_cnt_q == `ILA_LEN - 8'h02) begin
							word = {ila_cnt_q, `CHAR_ILA_END};
							kw = 2'b01;
						end else begin
							word = {ila_cnt_q, ila_cnt_q + 8'h01};
						end
					end
				end
				`TM_RPAT: begin
					if (enc_8b10b) begin
						// Encoder turns each pair into the listed 20-bit codes
						word = {rpat_o0, rpat_o1};
					end
				end
				default: word = conv_a_data[i*16 +: 16];
			endcase
			pat_d[i*16 +: 16] = en_d[i] ? word : 16'h0000;
			k_d[i*2 +: 2] = en_d[i] ? kw : 2'b00;
		end
		active_d = (test_mode == `TM_SHORT) || (test_mode == `TM_D215) ||
			((test_mode == `TM_K285 || test_mode == `TM_RILA ||
			test_mode == `TM_RPAT) && enc_8b10b);
	end

	// Registered outputs; converter B mirrors A in test, own data otherwise
	always @(posedge clk_sys) begin
		if (rst) begin
			st_q <= ST_IDLE;
			ila_cnt_q <= 8'h00;
			rpat_idx_q <= 4'h0;
			lane_a_q <= 96'h0;
			lane_b_q <= 96'h0;
			lane_a_k_q <= 12'h000;
			lane_b_k_q <= 12'h000;
			lane_en_q <= 6'h00;
			test_active_q <= 1'b0;
		end else begin
			st_q <= st_d;
			if (st_q == ST_ILA && st_d == ST_ILA) begin
				ila_cnt_q <= (ila_cnt_q == `ILA_LEN - 8'h02) ? 8'h00 : ila_cnt_q + 8'h02;
			end else begin
				ila_cnt_q <= 8'h00;
			end
			if (test_mode == `TM_RPAT) begin
				// Two octets per clock; twelve is even so the wrap is exact
				rpat_idx_q <= (rpat_idx_q == `RPAT_LEN - 4'h2) ? 4'h0 : rpat_idx_q + 4'h2;
			end else begin
				rpat_idx_q <= 4'h0;
			end
			lane_en_q <= en_d;
			test_active_q <= active_d;
			if (active_d) begin
				lane_a_q <= pat_d;
				lane_b_q <= pat_d;
				lane_a_k_q <= k_d;
				lane_b_k_q <= k_d;
			end else begin
				// K flags never ride on converter samples
				lane_a_q <= conv_a_data;
				lane_b_q <= conv_b_data;
				lane_a_k_q <= 12'h000;
				lane_b_k_q <= 12'h000;
			end
		end
	end
endmodule

// ### src/test_pattern_regs.vh
// Constants for the serial link test-pattern generator.
// Assumes inclusion by bare name from the design files.
`ifndef TEST_PATTERN_REGS_VH
`define TEST_PATTERN_REGS_VH
// Test mode selector codes
`define TM_OFF 3'h0
`define TM_SHORT 3'h1
`define TM_D215 3'h2
`define TM_K285 3'h3
`define TM_RILA 3'h4
`define TM_RPAT 3'h5
// Link configuration layout selector
`define CFG_F2S8 2'h0
`define CFG_F2S4 2'h1
`define CFG_F8 2'h2
// Characters
`define CHAR_D215 8'hB5
`define CHAR_K285 8'hBC
`define CHAR_ILA_START 8'h1C
`define CHAR_ILA_END 8'h7C
// Repeated alignment and RPAT sequence lengths in octets; lane count
`define ILA_LEN 8'h40
`define RPAT_LEN 4'hC
`define NUM_LANES 6
`endif

// ### src/rpat_rom.v
// Modified RPAT octet table, one octet per index.
// Assumes index below twelve; other indices give octet 0.
`timescale 1ns/1ps
`include "test_pattern_regs.vh"
module rpat_rom (
	input wire [3:0] idx,
	output reg [7:0] octet
);
	// Octets as presented to the 8b/10b encoder
	always @* begin
		case (idx)
			4'h0: octet = 8'hBE;
			4'h1: octet = 8'hD7;
			4'h2: octet = 8'h23;
			4'h3: octet = 8'h47;
			4'h4: octet = 8'h6B;
			4'h5: octet = 8'h8F;
			4'h6: octet = 8'hB3;
			4'h7: octet = 8'h14;
			4'h8: octet = 8'h5E;
			4'h9: octet = 8'hFB;
			4'hA: octet = 8'h35;
			4'hB: octet = 8'h59;
			default: octet = 8'hBE;
		endcase
	end
endmodule

// ### verification/rx_sync_model.sv
// Receiver sync request model.
// Assumes the bench drives req; HOLD sets receiver speed.
`timescale 1ns/1ps
module rx_sync_model #(
	parameter [7:0] HOLD = 8'h04
) (
	input wire clk_sys,
	input wire rst,
	input wire req,
	output reg sync_req_n
);
	reg [7:0] cnt_q;
	// Held low until the count runs out, like a slow receiver
	always @(posedge clk_sys) begin
		if (rst || req) begin
			cnt_q <= HOLD;
			sync_req_n <= 1'b0;
		end else if (cnt_q != 8'h00) begin
			cnt_q <= cnt_q - 8'h01;
		end else begin
			sync_req_n <= 1'b1;
		end
	end
endmodule

// ### verification/slt_checker.sv
// Port assertions for the pattern generator.
// Assumes bind onto its top module.
`timescale 1ns/1ps
`include "test_pattern_regs.vh"
module slt_checker (
	input wire clk_sys,
	input wire rst,
	input wire [2:0] test_mode,
	input wire [1:0] link_config_select,
	input wire enc_8b10b,
	input wire sync_req_n,
	input wire [95:0] conv_a_data,
	input wire [95:0] lane_a_q,
	input wire [95:0] lane_b_q,
	input wire [11:0] lane_a_k_q,
	input wire [5:0] lane_en_q,
	input wire test_active_q
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// One step of alignment mode
	sequence s_rila(n);
		test_mode == `TM_RILA && enc_8b10b && sync_req_n == n;
	endsequence
	a_d215_stream: assert property (test_mode == `TM_D215 |=> lane_a_q[15:0] == 16'hB5B5)
		else $error("bad D21.5");
	a_k285_stream: assert property (test_mode == `TM_K285 && enc_8b10b |=> lane_a_k_q[1:0] == 2'h3)
		else $error("bad K28.5");
	a_k285_refused: assert property (test_mode == `TM_K285 && !enc_8b10b |=> !test_active_q)
		else $error("K28.5 not refused");
	a_rpat_start: assert property (test_mode != `TM_RPAT ##1 test_mode == `TM_RPAT && enc_8b10b
		|=> lane_a_q[15:0] == 16'hBED7) else $error("bad RPAT start");
	a_rpat_wrap: assert property (test_mode == `TM_RPAT && lane_a_q[15:0] == 16'h3559
		&& test_active_q && enc_8b10b |=> lane_a_q[15:0] == 16'hBED7) else $error("bad RPAT wrap");
	a_b_mirror: assert property (test_active_q |-> lane_b_q == lane_a_q)
		else $error("B lanes differ");
	a_short_f2s4: assert property (test_mode == `TM_SHORT && link_config_select == `CFG_F2S4
		|=> lane_a_q == 96'h89AB_4567_0123 && lane_en_q == 6'h07) else $error("bad F2S4");
	a_rila_resync: assert property (s_rila(0) ##1 s_rila(0) |=> lane_a_q[15:0] == 16'hBCBC)
		else $error("no resync");
	a_ila_start: assert property (s_rila(0) ##1 s_rila(1) ##1 s_rila(1)
		|=> lane_a_q[15:0] == 16'h1C01 && lane_a_k_q[1:0] == 2'b10) else $error("no ILA");
	a_off_restore: assert property (test_mode == `TM_OFF
		|=> lane_a_q == $past(conv_a_data) && lane_a_k_q == 12'h000 && !test_active_q)
		else $error("samples not restored");
	a_rila_entry: assert property (test_mode != `TM_RILA ##1 s_rila(0)
		|=> lane_a_q[15:0] == 16'hBCBC) else $error("samples leak on ILA entry");
endmodule
bind serial_link_test_pattern_gen slt_checker u_chk (.clk_sys, .rst, .test_mode,
	.link_config_select, .enc_8b10b, .sync_req_n, .conv_a_data, .lane_a_q, .lane_b_q,
	.lane_a_k_q, .lane_en_q, .test_active_q);

// ### verification/tb_top.sv
// Self-checking bench for the pattern generator.
// Assumes the receiver model drives the sync request.
`timescale 1ns/1ps
`include "test_pattern_regs.vh"
module tb_top;
	reg clk_sys = 0, rst = 1, enc_8b10b = 1, rx_req = 1;
	reg [2:0] test_mode = 0;
	reg [1:0] link_config_select = 0;
	reg [95:0] conv_a_data = 96'h0011_2233_4455_6677_8899_AABB;
	reg [95:0] conv_b_data = 96'hF0E1_D2C3_B4A5_9687_7869_5A4B;
	reg [95:0] e;
	localparam [95:0] RP = 96'hBED7_2347_6B8F_B314_5EFB_3559;
	wire sync_req_n, test_active_q;
	wire [95:0] lane_a_q, lane_b_q;
	wire [11:0] lane_a_k_q, lane_b_k_q;
	wire [5:0] lane_en_q;
	integer failures = 0, tests_run = 0, i;
	always #2.5 clk_sys = ~clk_sys;
	rx_sync_model #(.HOLD(8'h04)) rx (.clk_sys, .rst, .req(rx_req), .sync_req_n);
	serial_link_test_pattern_gen dut (.clk_sys, .rst, .test_mode, .link_config_select,
		.enc_8b10b, .sync_req_n, .conv_a_data, .conv_b_data, .lane_a_q, .lane_b_q,
		.lane_a_k_q, .lane_b_k_q, .lane_en_q, .test_active_q);
	task close_out;
		if (failures == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task chk(input [99:0] got, input [99:0] exp);
		tests_run = tests_run + 1;
		if (got !== exp) begin
			failures = failures + 1;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Inputs change at the falling edge; one rising edge later they show
	task go(input [2:0] m, input [1:0] c, input en);
		@(negedge clk_sys);
		test_mode = m;
		link_config_select = c;
		enc_8b10b = en;
		@(negedge clk_sys);
	endtask
	task t_short;
		for (i = 0; i < 3; i = i + 1) begin
			go(`TM_SHORT, i[1:0], 1);
			e = i == 1 ? 96'h89AB_4567_0123 : 96'h4567_0123_CDEF_89AB_4567_0123;
			chk(lane_a_q, e);
			chk(lane_b_q, e);
			chk(lane_en_q, i == 1 ? 6'h07 : 6'h3F);
		end
	endtask
	task t_chars;
		go(`TM_D215, 0, 0);
		chk({lane_a_k_q, lane_a_q[15:0]}, 28'hB5B5);
		go(`TM_D215, 1, 1);
		chk(lane_a_q, 96'h0000_0000_0000_B5B5_B5B5_B5B5);
		go(`TM_K285, 0, 1);
		chk({lane_a_k_q[1:0], lane_b_q[15:0]}, 18'h3BCBC);
		chk(lane_b_k_q, 12'hFFF);
		go(`TM_K285, 0, 0);
		chk({test_active_q, lane_a_q}, {1'b0, conv_a_data});
		chk(lane_b_k_q, 12'h000);
	endtask
	task t_rpat;
		go(`TM_OFF, 0, 1);
		go(`TM_RPAT, 0, 1);
		// Seven pairs so the wrap back to the first pair is seen
		for (i = 0; i < 7; i = i + 1) begin
			chk({lane_a_k_q, lane_b_q[15:0]}, RP[95 - 16 * (i % 6) -: 16]);
			@(negedge clk_sys);
		end
		go(`TM_RPAT, 0, 0);
		chk({test_active_q, lane_a_q}, {1'b0, conv_a_data});
	endtask
	task t_rila;
		go(`TM_RILA, 0, 1);
		chk({lane_a_k_q[1:0], lane_a_q[15:0]}, 18'h3BCBC);
		@(negedge clk_sys);
		chk({lane_a_k_q[1:0], lane_a_q[15:0]}, 18'h3BCBC);
		rx_req = 0;
		for (i = 0; i < 20 && lane_a_q[15:0] !== 16'h1C01; i = i + 1) @(negedge clk_sys);
		chk({lane_a_k_q[1:0], lane_a_q[15:0]}, 18'h21C01);
		repeat (31) @(negedge clk_sys);
		chk({lane_a_k_q[1:0], lane_a_q[15:0]}, 18'h13E7C);
		@(negedge clk_sys);
		chk(lane_a_q[15:0], 16'h1C01);
		rx_req = 1;
		repeat (3) @(negedge clk_sys);
		chk({lane_a_k_q[1:0], lane_a_q[15:0]}, 18'h3BCBC);
	endtask
	task t_off;
		go(`TM_OFF, 0, 1);
		chk({test_active_q, lane_b_q}, {1'b0, conv_b_data});
		chk(lane_a_q, conv_a_data);
	endtask
	initial begin
		repeat (10) @(negedge clk_sys);
		chk({test_active_q, lane_a_q}, 100'h0);
		rst = 0;
		t_short;
		t_chars;
		t_rpat;
		t_rila;
		t_off;
		close_out;
	end
	// Watchdog at 1000 cycles, well past the fewer than a hundred cycles the tests take
	initial begin
		#5000;
		failures = failures + 1;
		close_out;
	end
endmodule
